/* File: core/lcdcc_defs.svh */
`ifndef LCDCC_DEFS_SVH
`define LCDCC_DEFS_SVH

// ****
// Display RAM geometry
// ****
`define LCDCC_RAM_DEPTH 7'h28
`define LCDCC_RAM_LAST 6'h27

// ****
// Slave address, upper six bits (lsb comes from a pin)
// ****
`define LCDCC_SLAVE_ADDR_HI 6'h1C

// ****
// Drive mode codes
// ****
`define LCDCC_MODE_STATIC 2'h1
`define LCDCC_MODE_MUX2 2'h2
`define LCDCC_MODE_MUX3 2'h3
`define LCDCC_MODE_MUX4 2'h0

// ****
// Event kinds passed from the link side
// ****
`define LCDCC_KIND_BYTE 2'h0
`define LCDCC_KIND_START 2'h1
`define LCDCC_KIND_STOP 2'h2

// ****
// Command byte fields
// ****
`define LCDCC_CONT_BIT 7
`define LCDCC_MSET_POS 5
`define LCDCC_MSET_VAL 2'h2
`define LCDCC_DSEL_POS 3
`define LCDCC_DSEL_VAL 4'hC
`define LCDCC_BLNK_VAL 4'hE
`define LCDCC_BSEL_POS 2
`define LCDCC_BSEL_VAL 5'h1E
`define LCDCC_BIAS_BIT 2
`define LCDCC_ENA_BIT 3
`define LCDCC_PWR_BIT 4
`define LCDCC_IBANK_BIT 1
`define LCDCC_OBANK_BIT 0
`define LCDCC_BALT_BIT 2

// ****
// Reset values of the status settings
// ****
`define LCDCC_RST_MODE 2'h0
`define LCDCC_RST_CONFIG_CMD_A 2'h0
`define LCDCC_RST_PTR 6'h00
`define LCDCC_RST_SUB 3'h0

// ****
// Cascade line pulse length in mclk cycles
// ****
`define LCDCC_SYNC_PULSE 4'h8

`endif

/* File: core/lcdcc_pkg.sv */
package lcdcc_pkg;

  // ****
  // Frame decoder states, one-hot
  // ****
  typedef enum logic [4:0] {
    LCDCC_ST_IDLE = 5'h01,
    LCDCC_ST_ADDR = 5'h02,
    LCDCC_ST_CMD = 5'h04,
    LCDCC_ST_DATA = 5'h08,
    LCDCC_ST_SKIP = 5'h10
  } lcdcc_state_t;

endpackage

/* File: core/lcdcc_xfer_if.sv */
`timescale 1ns/1ps
`default_nettype none

// ****
// Event word and answer crossing between link and core domains
// ****
interface lcdcc_xfer_if;
  logic req_tgl;
  logic [1:0] req_kind;
  logic [7:0] req_data;
  logic ack_tgl;
  logic ack_bit;

  modport link (output req_tgl, output req_kind, output req_data, input ack_tgl, input ack_bit);
  modport core (input req_tgl, input req_kind, input req_data, output ack_tgl, output ack_bit);
endinterface

`default_nettype wire

/* File: core/lcdcc_link.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lcdcc_defs.svh"

module lcdcc_link (
  input wire logic link_clk,
  input wire logic reset,
  input wire logic ev_start,
  input wire logic ev_stop,
  input wire logic ev_byte,
  input wire logic [7:0] ev_data,
  output logic ev_ready,
  output logic stretch,
  output logic ack_valid,
  output logic ack_bit,
  lcdcc_xfer_if.link xf
);

  logic busy_q, busy_d;
  logic tgl_q, tgl_d;
  logic [1:0] kind_q, kind_d;
  logic [7:0] data_q, data_d;
  logic as1_q, as2_q, as3_q, seen_q, seen_d;
  logic av_q, av_d;
  logic ab_q, ab_d;
  logic take;

  assign take = !busy_q && (ev_start || ev_stop || ev_byte);

  // ****
  // Capture one event, hold it until the core answers
  // ****
  always_comb begin
    busy_d = busy_q;
    tgl_d = tgl_q;
    kind_d = kind_q;
    data_d = data_q;
    seen_d = seen_q;
    av_d = 1'b0;
    ab_d = ab_q;
    if (take) begin
      busy_d = 1'b1;
      tgl_d = !tgl_q;
      data_d = ev_data;
      if (ev_start) begin
        kind_d = `LCDCC_KIND_START;
      end else if (ev_stop) begin
        kind_d = `LCDCC_KIND_STOP;
      end else begin
        kind_d = `LCDCC_KIND_BYTE;
      end
    end else if (busy_q && as2_q == as3_q && as3_q != seen_q) begin // Answer steady in stages two and three
      busy_d = 1'b0;
      seen_d = as3_q;
      av_d = (kind_q == `LCDCC_KIND_BYTE);
      ab_d = xf.ack_bit;
    end
  end

  // Registers of the link domain
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      busy_q <= 1'b0;
      tgl_q <= 1'b0;
      kind_q <= 2'h0;
      data_q <= 8'h00;
      as1_q <= 1'b0;
      as2_q <= 1'b0;
      as3_q <= 1'b0;
      seen_q <= 1'b0;
      av_q <= 1'b0;
      ab_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      tgl_q <= tgl_d;
      kind_q <= kind_d;
      data_q <= data_d;
      as1_q <= xf.ack_tgl;
      as2_q <= as1_q;
      as3_q <= as2_q;
      seen_q <= seen_d;
      av_q <= av_d;
      ab_q <= ab_d;
    end
  end

  // Outputs toward the serial front end and the core
  assign ev_ready = !busy_q;
  assign stretch = busy_q; // Clock held low while the core is working
  assign ack_valid = av_q;
  assign ack_bit = ab_q;
  assign xf.req_tgl = tgl_q;
  assign xf.req_kind = kind_q;
  assign xf.req_data = data_q;

endmodule

`default_nettype wire

/* File: core/lcdcc_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lcdcc_defs.svh"

// Notes on behaviour
// - Command msb set means another command follows; clear means display data follows.
// - Mode-set (bits 6:5 = 10) low bits 01, 10, 11, 00 pick static, 1:2, 1:3, 1:4.
// - Mode-set bit 2 picks one-third bias at 0, one-half bias at 1.
// - Mode-set bit 3 blanks the display at 0, shows it at 1.
// - Mode-set bit 4 picks normal at 0, power saving at 1.
// - Bit 6 clear loads six low bits into the RAM data pointer.
// - Bits 6:3 = 1100 load three low bits into the subaddress counter.
// - Bank-select bit 1 picks the RAM bank that stores incoming data.
// - Bank-select bit 0 picks the RAM bank shown on the display.
// - Bank-select is ignored in 1:3 and 1:4 drive modes.
// - Bits 6:3 = 1110 is config_cmd_a; low bits pick off, 2, 1, 0.5 Hz.
// - Config_cmd_a bit 2 picks blanking config_cmd_a at 0, bank alternation at 1.
// - No bank alternation blinking in 1:3 and 1:4 drive modes.
// - Execute commands, hold settings, write data bytes in mode filling order.
// - Each stored byte advances pointer, and subaddress counter on wrap.
// - Data bytes acknowledged only on subaddress match; address and commands by all devices whose lsb pin matches.
// - Up to sixteen devices: 3-bit subaddress plus slave address lsb pin.
// - Pull cascade line low, open drain, at onset of last backplane phase.
// - When not driving, watch the cascade line and realign on assertion.
// - Reset puts every device in the same backplane phase without the line.

module lcdcc_core #(
  parameter logic [3:0] SYNC_PULSE = `LCDCC_SYNC_PULSE
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic ev_start,
  input wire logic ev_stop,
  input wire logic ev_byte,
  input wire logic [7:0] ev_data,
  output logic ev_ready,
  output logic stretch,
  output logic ack_valid,
  output logic ack_bit,
  input wire logic slave_addr_lsb_pin,
  input wire logic subaddr_bit2,
  input wire logic subaddr_bit1,
  input wire logic subaddr_bit0,
  input wire logic frame_tick,
  input wire logic config_cmd_a_phase,
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe,
  output logic [1:0] backplane_output_phase,
  output logic drive_mode_hi,
  output logic drive_mode_lo,
  output logic bias_half,
  output logic power_saving_select,
  output logic display_on,
  output logic config_cmd_a_rate_hi,
  output logic config_cmd_a_rate_lo,
  output logic config_cmd_a_alternate,
  output logic in_bank,
  output logic out_bank,
  output logic [5:0] data_pointer,
  output logic [2:0] subaddr_count,
  input wire logic [5:0] rd_addr,
  output logic [3:0] rd_data
);

  // ****
  // Link side and crossing
  // ****
  lcdcc_xfer_if xf ();

  lcdcc_link u_link (
    .link_clk(link_clk),
    .reset(reset),
    .ev_start(ev_start),
    .ev_stop(ev_stop),
    .ev_byte(ev_byte),
    .ev_data(ev_data),
    .ev_ready(ev_ready),
    .stretch(stretch),
    .ack_valid(ack_valid),
    .ack_bit(ack_bit),
    .xf(xf.link)
  );

  // ****
  // Input synchronisers, three stages each
  // ****
  logic [5:0] s1_q, s2_q, s3_q;
  logic [5:0] pin_in;
  logic [5:0] flt_q, flt_d;
  logic seen_q;
  logic ev_new;

  assign pin_in = {xf.req_tgl, sync_in, slave_addr_lsb_pin, subaddr_bit2, subaddr_bit1, subaddr_bit0};

  // A level counts once stages two and three agree
  always_comb begin
    flt_d = flt_q;
    for (int i = 0; i < 6; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        flt_d[i] = s3_q[i];
      end
    end
  end

  // Stages reset to idle levels: no false event or line edge after reset
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s1_q <= 6'h10;
      s2_q <= 6'h10;
      s3_q <= 6'h10;
      flt_q <= 6'h10;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      flt_q <= flt_d;
    end
  end

  // Request toggle and subaddress are meaningful only after filtering
  assign ev_new = (flt_q[5] != seen_q);

  // ****
  // Frame decoder and status settings
  // ****
  lcdcc_pkg::lcdcc_state_t st_q, st_d;
  logic [1:0] mode_q, mode_d;
  logic bias_q, bias_d, ena_q, ena_d, pwr_q, pwr_d;
  logic [1:0] brate_q, brate_d;
  logic balt_q, balt_d, ibank_q, ibank_d, obank_q, obank_d;
  logic [5:0] ptr_q, ptr_d;
  logic [2:0] sub_q, sub_d;
  logic ackt_q, ackt_d, ackb_q, ackb_d, seen_d;
  logic wr_en;
  logic [7:0] byte_in;
  logic two_bank;
  logic [3:0] step;
  logic [6:0] ptr_sum;

  assign byte_in = xf.req_data;
  assign two_bank = (mode_q == `LCDCC_MODE_STATIC) || (mode_q == `LCDCC_MODE_MUX2);

  // RAM addresses consumed per display byte in each mode
  always_comb begin
    case (mode_q)
      `LCDCC_MODE_STATIC: step = 4'h8;
      `LCDCC_MODE_MUX2: step = 4'h4;
      `LCDCC_MODE_MUX3: step = 4'h3;
      default: step = 4'h2;
    endcase
  end

  assign ptr_sum = {1'b0, ptr_q} + {3'h0, step};

  always_comb begin
    st_d = st_q;
    mode_d = mode_q;
    bias_d = bias_q;
    ena_d = ena_q;
    pwr_d = pwr_q;
    brate_d = brate_q;
    balt_d = balt_q;
    ibank_d = ibank_q;
    obank_d = obank_q;
    ptr_d = ptr_q;
    sub_d = sub_q;
    ackt_d = ackt_q;
    ackb_d = ackb_q;
    seen_d = seen_q;
    wr_en = 1'b0;
    if (ev_new) begin
      seen_d = flt_q[5];
      ackt_d = !ackt_q;
      ackb_d = 1'b0;
      if (xf.req_kind == `LCDCC_KIND_START) begin
        st_d = lcdcc_pkg::LCDCC_ST_ADDR;
      end else if (xf.req_kind == `LCDCC_KIND_STOP) begin
        st_d = lcdcc_pkg::LCDCC_ST_IDLE;
      end else begin
        case (st_q)
          lcdcc_pkg::LCDCC_ST_ADDR: begin
            // Write address with our lsb pin; other lsb ignores the frame
            if (byte_in[7:2] == `LCDCC_SLAVE_ADDR_HI && byte_in[1] == flt_q[3] && !byte_in[0]) begin
              st_d = lcdcc_pkg::LCDCC_ST_CMD;
              ackb_d = 1'b1;
            end else begin
              st_d = lcdcc_pkg::LCDCC_ST_SKIP;
            end
          end
          lcdcc_pkg::LCDCC_ST_CMD: begin
            ackb_d = 1'b1;
            if (!byte_in[`LCDCC_CONT_BIT]) begin
              st_d = lcdcc_pkg::LCDCC_ST_DATA;
            end
            if (!byte_in[6]) begin
              ptr_d = byte_in[5:0];
            end else if (byte_in[6:`LCDCC_MSET_POS] == `LCDCC_MSET_VAL) begin
              mode_d = byte_in[1:0];
              bias_d = byte_in[`LCDCC_BIAS_BIT];
              ena_d = byte_in[`LCDCC_ENA_BIT];
              pwr_d = byte_in[`LCDCC_PWR_BIT];
            end else if (byte_in[6:`LCDCC_DSEL_POS] == `LCDCC_DSEL_VAL) begin
              sub_d = byte_in[2:0];
            end else if (byte_in[6:`LCDCC_DSEL_POS] == `LCDCC_BLNK_VAL) begin
              brate_d = byte_in[1:0];
              balt_d = byte_in[`LCDCC_BALT_BIT];
            end else if (byte_in[6:`LCDCC_BSEL_POS] == `LCDCC_BSEL_VAL && two_bank) begin
              ibank_d = byte_in[`LCDCC_IBANK_BIT];
              obank_d = byte_in[`LCDCC_OBANK_BIT];
            end
          end
          lcdcc_pkg::LCDCC_ST_DATA: begin
            // Every device tracks pointer and counter; only the match stores
            if (sub_q == flt_q[2:0]) begin
              ackb_d = 1'b1;
              wr_en = 1'b1;
            end
            if (ptr_sum >= `LCDCC_RAM_DEPTH) begin
              ptr_d = 6'(ptr_sum - `LCDCC_RAM_DEPTH);
              sub_d = sub_q + 3'h1;
            end else begin
              ptr_d = ptr_sum[5:0];
            end
          end
          default: begin
            st_d = st_q;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_q <= lcdcc_pkg::LCDCC_ST_IDLE;
      mode_q <= `LCDCC_RST_MODE;
      bias_q <= 1'b0;
      ena_q <= 1'b0;
      pwr_q <= 1'b0;
      brate_q <= `LCDCC_RST_CONFIG_CMD_A;
      balt_q <= 1'b0;
      ibank_q <= 1'b0;
      obank_q <= 1'b0;
      ptr_q <= `LCDCC_RST_PTR;
      sub_q <= `LCDCC_RST_SUB;
      ackt_q <= 1'b0;
      ackb_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      st_q <= st_d;
      mode_q <= mode_d;
      bias_q <= bias_d;
      ena_q <= ena_d;
      pwr_q <= pwr_d;
      brate_q <= brate_d;
      balt_q <= balt_d;
      ibank_q <= ibank_d;
      obank_q <= obank_d;
      ptr_q <= ptr_d;
      sub_q <= sub_d;
      ackt_q <= ackt_d;
      ackb_q <= ackb_d;
      seen_q <= seen_d;
    end
  end

  assign xf.ack_tgl = ackt_q;
  assign xf.ack_bit = ackb_q;

  // ****
  // Display RAM, one generated cell per address
  // ****
  logic [3:0] cell_rd [0:39];

  // RAM address and bit taken by byte bit j (j = 0 is the msb)
  function automatic logic [5:0] fill_addr(input logic [1:0] md, input logic [5:0] base, input int j);
    logic [6:0] s;
    s = 7'h00;
    case (md)
      `LCDCC_MODE_STATIC: s = {1'b0, base} + 7'(j);
      `LCDCC_MODE_MUX2: s = {1'b0, base} + 7'(j / 2);
      `LCDCC_MODE_MUX3: s = {1'b0, base} + 7'(j / 3);
      default: s = {1'b0, base} + 7'(j / 4);
    endcase
    if (s >= `LCDCC_RAM_DEPTH) begin
      s = s - `LCDCC_RAM_DEPTH;
    end
    return s[5:0];
  endfunction

  function automatic logic [1:0] fill_bit(input logic [1:0] md, input logic bank, input int j);
    logic [1:0] b;
    b = 2'h0;
    case (md)
      `LCDCC_MODE_STATIC: b = {bank, 1'b0};
      `LCDCC_MODE_MUX2: b = {bank, 1'(j % 2)};
      `LCDCC_MODE_MUX3: b = 2'(j % 3);
      default: b = 2'(j % 4);
    endcase
    return b;
  endfunction

  for (genvar e = 0; e < 40; e++) begin : g_cell
    logic [3:0] cell_q, cell_d;

    // Store the byte bits that land in this address
    always_comb begin
      cell_d = cell_q;
      for (int j = 0; j < 8; j++) begin
        if (wr_en && fill_addr(mode_q, ptr_q, j) == 6'(e)) begin
          cell_d[fill_bit(mode_q, ibank_q, j)] = byte_in[7 - j];
        end
      end
    end

    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        cell_q <= 4'h0;
      end else begin
        cell_q <= cell_d;
      end
    end

    assign cell_rd[e] = cell_q;
  end

  // ****
  // Read-out, banks and blinking
  // ****
  logic bank_eff;
  logic [3:0] rd_q, rd_d;
  logic [3:0] cell_sel;

  assign bank_eff = obank_q ^ (two_bank && balt_q && brate_q != 2'h0 && config_cmd_a_phase);
  assign cell_sel = (rd_addr > `LCDCC_RAM_LAST) ? 4'h0 : cell_rd[rd_addr];

  // Selected output bank shifted into the low bits
  always_comb begin
    rd_d = cell_sel;
    if (two_bank && bank_eff) begin
      rd_d = {2'h0, cell_sel[3:2]};
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rd_q <= 4'h0;
    end else begin
      rd_q <= rd_d;
    end
  end

  // ****
  // Backplane phase and cascade line
  // ****
  logic [1:0] ph_q, ph_d, ph_last;
  logic [3:0] scnt_q, scnt_d;
  logic line_fall;

  assign ph_last = mode_q - 2'h1; // 1 -> 0, 2 -> 1, 3 -> 2, 0 -> 3
  assign line_fall = flt_q[4] && !flt_d[4];

  always_comb begin
    ph_d = ph_q;
    scnt_d = (scnt_q != 4'h0) ? scnt_q - 4'h1 : 4'h0;
    if (scnt_q == 4'h0 && line_fall) begin
      ph_d = ph_last;
    end else if (frame_tick) begin
      ph_d = (ph_q >= ph_last) ? 2'h0 : ph_q + 2'h1;
      if (ph_d == ph_last) begin
        scnt_d = SYNC_PULSE;
      end
    end
  end

  // Same reset phase in every device keeps the cascade aligned
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ph_q <= 2'h0;
      scnt_q <= 4'h0;
    end else begin
      ph_q <= ph_d;
      scnt_q <= scnt_d;
    end
  end

  // ****
  // Outputs
  // ****
  assign sync_out = 1'b0;
  assign sync_oe = (scnt_q != 4'h0);
  assign backplane_output_phase = ph_q;
  assign drive_mode_hi = mode_q[1];
  assign drive_mode_lo = mode_q[0];
  assign bias_half = bias_q;
  assign power_saving_select = pwr_q;
  assign display_on = ena_q && !(brate_q != 2'h0 && !balt_q && config_cmd_a_phase);
  assign config_cmd_a_rate_hi = brate_q[1];
  assign config_cmd_a_rate_lo = brate_q[0];
  assign config_cmd_a_alternate = balt_q;
  assign in_bank = ibank_q;
  assign out_bank = bank_eff;
  assign data_pointer = ptr_q;
  assign subaddr_count = sub_q;
  assign rd_data = rd_q;

endmodule

`default_nettype wire

/* File: verif/lcdcc_core_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Checker on the core ports
// ****
module lcdcc_core_sva #(
  parameter logic [3:0] SYNC_PULSE = 4'h8
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic ev_ready,
  input wire logic ack_valid,
  input wire logic ack_bit,
  input wire logic sync_in,
  input wire logic sync_out,
  input wire logic sync_oe,
  input wire logic [1:0] backplane_output_phase,
  input wire logic drive_mode_hi,
  input wire logic drive_mode_lo,
  input wire logic display_on,
  input wire logic config_cmd_a_rate_hi,
  input wire logic config_cmd_a_rate_lo,
  input wire logic config_cmd_a_alternate,
  input wire logic config_cmd_a_phase,
  input wire logic out_bank,
  input wire logic [5:0] rd_addr,
  input wire logic [3:0] rd_data
);
  logic [1:0] last_ph;
  logic [3:0] cnt_d;
  logic [3:0] cnt_q;
  // Last backplane phase of the active mode
  assign last_ph = {drive_mode_hi, drive_mode_lo} - 2'h1;
  // Length so far of the cascade pulse
  always_comb begin
    cnt_d = sync_oe ? cnt_q + 4'h1 : 4'h0;
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  a_reset_phase: assert property (@(posedge mclk) disable iff (reset)
    $fell(reset) |-> backplane_output_phase == 2'h0 && !sync_oe) else $error("phase not cleared");
  a_sync_low: assert property (@(posedge mclk) disable iff (reset)
    sync_oe |-> !sync_out) else $error("cascade line driven high");
  a_sync_phase: assert property (@(posedge mclk) disable iff (reset)
    $rose(sync_oe) |-> backplane_output_phase == last_ph) else $error("pulse not at last phase");
  a_pulse_max: assert property (@(posedge mclk) disable iff (reset)
    sync_oe |-> cnt_q < SYNC_PULSE) else $error("pulse too long");
  a_pulse_len: assert property (@(posedge mclk) disable iff (reset)
    $fell(sync_oe) |-> cnt_q == SYNC_PULSE) else $error("pulse too short");
  a_sync_realign: assert property (@(posedge mclk) disable iff (reset)
    !sync_oe && $fell(sync_in) |-> ##[1:12] backplane_output_phase == last_ph) else $error("no realign");
  a_bank_fixed: assert property (@(posedge mclk) disable iff (reset)
    drive_mode_hi == drive_mode_lo && $stable(last_ph) |-> $stable(out_bank)) else $error("bank moved");
  a_blank_config_cmd_a: assert property (@(posedge mclk) disable iff (reset)
    (config_cmd_a_rate_hi || config_cmd_a_rate_lo) && !config_cmd_a_alternate && config_cmd_a_phase |-> !display_on)
    else $error("display not blanked");
  a_rd_range: assert property (@(posedge mclk) disable iff (reset)
    rd_addr > 6'h27 |=> rd_data == 4'h0) else $error("read beyond last address");
  a_ack_single: assert property (@(posedge link_clk) disable iff (reset)
    ack_valid |-> ev_ready ##1 !ack_valid) else $error("answer not single");
  c_pulse: cover property (@(posedge mclk) disable iff (reset) $rose(sync_oe));
  c_ack: cover property (@(posedge link_clk) disable iff (reset) ack_valid && ack_bit);
  c_nak: cover property (@(posedge link_clk) disable iff (reset) ack_valid && !ack_bit);
endmodule
bind lcdcc_core lcdcc_core_sva #(.SYNC_PULSE(SYNC_PULSE)) u_sva (.mclk(mclk), .reset(reset),
  .link_clk(link_clk), .ev_ready(ev_ready), .ack_valid(ack_valid), .ack_bit(ack_bit),
  .sync_in(sync_in), .sync_out(sync_out), .sync_oe(sync_oe), .backplane_output_phase(backplane_output_phase),
  .drive_mode_hi(drive_mode_hi), .drive_mode_lo(drive_mode_lo), .display_on(display_on),
  .config_cmd_a_rate_hi(config_cmd_a_rate_hi), .config_cmd_a_rate_lo(config_cmd_a_rate_lo), .config_cmd_a_alternate(config_cmd_a_alternate),
  .out_bank(out_bank), .rd_addr(rd_addr), .rd_data(rd_data), .config_cmd_a_phase(config_cmd_a_phase));
`default_nettype wire

/* File: verif/lcdcc_master.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Bus master: hands events to the link side
// ****
module lcdcc_master (
  input wire logic link_clk,
  input wire logic ev_ready,
  input wire logic ack_valid,
  input wire logic ack_bit,
  output logic ev_start,
  output logic ev_stop,
  output logic ev_byte,
  output logic [7:0] ev_data
);
  // Idle bus
  initial begin
    {ev_start, ev_stop, ev_byte} = 3'h0;
    ev_data = 8'h00;
  end
  // One event, k is {start, stop, byte}; held until taken
  task ev(input logic [2:0] k, input logic [7:0] d, output logic a, output logic g);
    int n;
    n = 0;
    @(negedge link_clk);
    {ev_start, ev_stop, ev_byte} = k;
    ev_data = d;
    while (!ev_ready && n < 12) begin
      @(negedge link_clk);
      n++;
    end
    @(posedge link_clk);
    @(negedge link_clk);
    {ev_start, ev_stop, ev_byte} = 3'h0;
    ev_data = ~d; // Released data shows no stale value
    g = n < 12;
    n = 0;
    while (k[0] && !ack_valid && n < 12) begin
      @(posedge link_clk);
      #1;
      n++;
    end
    g = g && (!k[0] || ack_valid);
    a = ack_bit;
  endtask
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lcdcc_defs.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
// ****
// Core testbench
// ****
module testbench;
  logic mclk, reset, link_clk, ev_start, ev_stop, ev_byte, ev_ready, stretch, ack_valid, ack_bit;
  logic slave_addr_lsb_pin, subaddr_bit2, subaddr_bit1, subaddr_bit0, frame_tick, config_cmd_a_phase;
  logic sync_in, sync_out, sync_oe, drive_mode_hi, drive_mode_lo, bias_half, power_saving_select;
  logic display_on, config_cmd_a_rate_hi, config_cmd_a_rate_lo, config_cmd_a_alternate, in_bank, out_bank, ext_pull, dm;
  logic [7:0] ev_data;
  logic [1:0] backplane_output_phase;
  logic [5:0] data_pointer, rd_addr;
  logic [2:0] subaddr_count;
  logic [3:0] rd_data;
  logic [0:7][7:0] q;
  logic [8:0] ak;
  int failures, compares;
  // Open-drain cascade line with pull-up
  assign sync_in = (sync_oe ? sync_out : 1'b1) & ~ext_pull;
  lcdcc_core #(.SYNC_PULSE(4'h8)) i_lcdcc_core (.mclk(mclk), .reset(reset), .link_clk(link_clk),
    .ev_start(ev_start), .ev_stop(ev_stop), .ev_byte(ev_byte), .ev_data(ev_data), .ev_ready(ev_ready),
    .stretch(stretch), .ack_valid(ack_valid), .ack_bit(ack_bit), .slave_addr_lsb_pin(slave_addr_lsb_pin),
    .subaddr_bit2(subaddr_bit2), .subaddr_bit1(subaddr_bit1), .subaddr_bit0(subaddr_bit0),
    .frame_tick(frame_tick), .config_cmd_a_phase(config_cmd_a_phase), .sync_in(sync_in), .sync_out(sync_out),
    .sync_oe(sync_oe), .backplane_output_phase(backplane_output_phase), .drive_mode_hi(drive_mode_hi),
    .drive_mode_lo(drive_mode_lo), .bias_half(bias_half), .power_saving_select(power_saving_select),
    .display_on(display_on), .config_cmd_a_rate_hi(config_cmd_a_rate_hi), .config_cmd_a_rate_lo(config_cmd_a_rate_lo),
    .config_cmd_a_alternate(config_cmd_a_alternate), .in_bank(in_bank), .out_bank(out_bank),
    .data_pointer(data_pointer), .subaddr_count(subaddr_count), .rd_addr(rd_addr), .rd_data(rd_data));
  lcdcc_master u_m (.link_clk(link_clk), .ev_ready(ev_ready), .ack_valid(ack_valid), .ack_bit(ack_bit),
    .ev_start(ev_start), .ev_stop(ev_stop), .ev_byte(ev_byte), .ev_data(ev_data));
  // Core clock and free link clock of unrelated phase
  always #20 mclk = ~mclk;
  initial begin
    link_clk = 1'b0;
    #7;
    forever #32 link_clk = ~link_clk;
  end
  task end_sim;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task put(input logic [2:0] k, input logic [7:0] d, output logic a);
    logic g;
    u_m.ev(k, d, a, g);
    if (!g) begin
      failures++;
      end_sim();
    end
  endtask
  // Start, address with lsb l, n bytes from q, stop
  task frame(input int n, input logic l);
    ak = 9'h000;
    put(3'h4, 8'h00, dm);
    put(3'h1, {`LCDCC_SLAVE_ADDR_HI, l, 1'b0}, ak[0]);
    for (int i = 0; i < n; i++) put(3'h1, q[i], ak[i + 1]);
    put(3'h2, 8'h00, dm);
  endtask
  task rd(input logic [5:0] a);
    @(negedge mclk);
    rd_addr = a;
    repeat (2) @(negedge mclk);
  endtask
  task phase(input logic v);
    @(negedge mclk);
    config_cmd_a_phase = v;
    repeat (2) @(negedge mclk);
  endtask
  task t_modes;
    `CHK({drive_mode_hi, drive_mode_lo, display_on, data_pointer}, 9'h000)
    for (int i = 0; i < 4; i++) begin
      q[0] = {3'h2, i[0], i[1], ~i[0], i[1:0]};
      frame(1, slave_addr_lsb_pin);
      `CHK(ak[1:0], 2'h3)
      `CHK({stretch, ev_ready}, 2'h2)
      `CHK({drive_mode_hi, drive_mode_lo}, i[1:0])
      `CHK({power_saving_select, display_on, bias_half}, {i[0], i[1], ~i[0]})
    end
  endtask
  task t_data;
    q[0:4] = {8'hC9, 8'hE0, 8'h00, 8'hA5, 8'h3C};
    frame(5, slave_addr_lsb_pin);
    `CHK(ak, 9'h03F)
    `CHK(data_pointer, 6'h10)
    for (int k = 0; k < 16; k++) begin
      rd(k[5:0]);
      `CHK(rd_data, {3'h0, k < 8 ? q[3][7 - k] : q[4][15 - k]})
    end
    q[0:2] = {8'h20, 8'h96, 8'hFF}; // Pointer 32, then two bytes
    frame(3, slave_addr_lsb_pin);
    `CHK(ak[3:0], 4'h7)
    `CHK({subaddr_count, data_pointer}, {3'h1, 6'h08})
    rd(6'h20);
    `CHK(rd_data, 4'h1)
    rd(6'h01);
    `CHK(rd_data, 4'h0)
    rd(6'h28);
    `CHK(rd_data, 4'h0)
  endtask
  task t_bank;
    q[0:1] = {8'hE2, 8'h7B}; // Subaddress 2, both banks 1
    frame(2, slave_addr_lsb_pin);
    `CHK({subaddr_count, in_bank, out_bank}, 5'h0B)
    rd(6'h20);
    `CHK(rd_data, 4'h0)
    q[0:1] = {8'hCB, 8'h78}; // Mux3, then bank 0 request
    frame(2, slave_addr_lsb_pin);
    `CHK({in_bank, out_bank}, 2'h3)
  endtask
  task t_config_cmd_a;
    for (int r = 0; r < 4; r++) begin
      q[0] = {6'h1C, r[1:0]};
      frame(1, slave_addr_lsb_pin);
      `CHK({config_cmd_a_rate_hi, config_cmd_a_rate_lo}, r[1:0])
    end
    phase(1'b1);
    `CHK(display_on, 1'b0)
    phase(1'b0);
    `CHK(display_on, 1'b1)
    q[0:2] = {8'hC9, 8'hF8, 8'h75}; // Static, banks 0, alternation
    frame(3, slave_addr_lsb_pin);
    phase(1'b1);
    `CHK({out_bank, display_on}, 2'h3)
    phase(1'b0);
    `CHK(out_bank, 1'b0)
    q[0] = 8'h48; // Mux4 with display on
    frame(1, slave_addr_lsb_pin);
    phase(1'b1);
    `CHK(out_bank, 1'b0)
    phase(1'b0);
  endtask
  task t_misc;
    q[0] = 8'h7F; // Undefined pattern
    frame(1, slave_addr_lsb_pin);
    `CHK(ak[1], 1'b1)
    `CHK({drive_mode_hi, drive_mode_lo, in_bank, config_cmd_a_alternate, data_pointer}, 10'h048)
    slave_addr_lsb_pin = 1'b1;
    repeat (8) @(negedge mclk);
    q[0] = 8'h4B;
    frame(1, 1'b0);
    `CHK({ak[1:0], drive_mode_lo}, 3'h0)
  endtask
  task t_sync;
    ext_pull = 1'b1;
    repeat (6) @(negedge mclk);
    ext_pull = 1'b0;
    for (int w = 0; w < 16 && backplane_output_phase !== 2'h3; w++) @(negedge mclk);
    `CHK(backplane_output_phase, 2'h3)
    for (int t = 0; t < 4; t++) begin
      frame_tick = 1'b1;
      @(negedge mclk);
      frame_tick = 1'b0;
      repeat (12) @(negedge mclk);
    end
    `CHK({backplane_output_phase, sync_oe}, 3'h6)
    frame_tick = 1'b1;
    @(negedge mclk);
    frame_tick = 1'b0;
    @(negedge mclk);
    `CHK({backplane_output_phase, sync_oe}, 3'h0)
  endtask
  initial begin
    {mclk, reset, slave_addr_lsb_pin, frame_tick, config_cmd_a_phase, ext_pull} = 6'h10;
    {subaddr_bit2, subaddr_bit1, subaddr_bit0} = 3'h0;
    rd_addr = 6'h00;
    failures = 0;
    compares = 0;
    repeat (4) @(negedge mclk);
    reset = 1'b0;
    t_modes();
    t_data();
    t_bank();
    t_config_cmd_a();
    t_misc();
    t_sync();
    end_sim();
  end
endmodule
`default_nettype wire
